// file: src/ltre_cfg.svh
// register offsets, field positions, opcodes and fault codes of the load/trace/rights unit
`ifndef LTRE_CFG_SVH
`define LTRE_CFG_SVH
// ----------------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------
`define LTRE_OFF_PROC_CTRL 8'h00
`define LTRE_OFF_TRACE_CTRL 8'h04
`define LTRE_OFF_INT_STATUS 8'h08
`define LTRE_OFF_INT_MASK 8'h0C
`define LTRE_OFF_UNIT_STATE 8'h10
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LTRE_BIT_TRACE_EN 0
`define LTRE_BIT_FAULT_PEND 10
`define LTRE_BIT_BP_EVENT 23
`define LTRE_RIGHTS_LSB 1
`define LTRE_RIGHTS_MSB 2
// ----------------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------------
`define LTRE_INT_BP 0
`define LTRE_INT_BAD_DESC 1
`define LTRE_INT_SEG_LEN 2
`define LTRE_INT_LOAD_DONE 3
`define LTRE_INT_INSP_DONE 4
`define LTRE_INT_W 5
// ----------------------------------------------------------------------
// opcodes: register format full 12 bits, memory format in bits 11:4
// ----------------------------------------------------------------------
`define LTRE_OP_FMARK 12'h66C
`define LTRE_OP_INSPACC 12'h613
`define LTRE_OP_LDOB 8'h80
`define LTRE_OP_LDOS 8'h88
`define LTRE_OP_LDIB 8'hC0
`define LTRE_OP_LDIS 8'hC8
`define LTRE_OP_LOAD_WORD_INSTR 8'h90
`define LTRE_OP_LDL 8'h98
`define LTRE_OP_LDT 8'hA0
`define LTRE_OP_LDQ 8'hB0
// ----------------------------------------------------------------------
// fault codes
// ----------------------------------------------------------------------
`define LTRE_FLT_NONE 3'h0
`define LTRE_FLT_BAD_DESC 3'h1
`define LTRE_FLT_SEG_LEN 3'h2
`endif

// file: src/ltre_pkg.sv
// types of the load/trace/rights unit
package ltre_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_TRACE = 2'b10
  } ltre_state_t;

  typedef enum logic [2:0] {
    K_BYTE_ORD = 3'b000,
    K_BYTE_INT = 3'b001,
    K_HALF_ORD = 3'b010,
    K_HALF_INT = 3'b011,
    K_WORDS = 3'b100,
    K_INSP = 3'b101
  } ltre_kind_t;

  typedef struct packed {
    ltre_state_t st;
    ltre_kind_t kind;
    logic [4:0] dst;
    logic [31:0] addr;
    logic [2:0] cnt;
    logic [2:0] total;
    logic trace_en;
    logic fault_pend;
    logic bp_evt;
    logic [4:0] int_stat;
    logic [4:0] int_mask;
    logic [31:0] rdata;
    logic irq;
    logic busy;
    logic done;
    logic rf_we;
    logic [4:0] rf_waddr;
    logic [31:0] rf_wdata;
    logic mem_req;
    logic mem_pte;
    logic [31:0] mem_addr;
    logic fault_valid;
    logic [2:0] fault_code;
    logic trace_fault;
  } ltre_state_reg_t;
endpackage

// file: src/ltre_unit.sv
// execution of force-mark, access-rights inspection and the load family
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "ltre_cfg.svh"

// Operation
// - force-mark with trace enabled makes breakpoint event
// - event sets pending bit10 and event bit23
// - trace fault raised before next instruction starts
// - inspect rights of byte into destination register
// - entry bits 2:1 go to destination bits 1:0
// - bad descriptor fault, else segment length fault
// - load from source address, lowest register first
// - byte and halfword loads widen to 32 bits
// - word/long/triple/quad copy 4/8/12/16 bytes
// - overrun past last register gives undefined result
module ltre_unit (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // instruction issue
  input wire logic instr_valid,
  input wire logic [11:0] instr_op,
  input wire logic [4:0] instr_dst,
  input wire logic [31:0] instr_src,
  output logic instr_busy,
  output logic instr_done,
  // segment information of the current source address
  input wire logic seg_desc_ok,
  input wire logic [31:0] seg_length,
  // memory subsystem
  output logic mem_req,
  output logic mem_pte,
  output logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // register file write port
  output logic rf_we,
  output logic [4:0] rf_waddr,
  output logic [31:0] rf_wdata,
  // faults
  output logic fault_valid,
  output logic [2:0] fault_code,
  output logic trace_fault
);

  ltre_pkg::ltre_state_reg_t q;
  ltre_pkg::ltre_state_reg_t n;
  logic [`LTRE_INT_W-1:0] ev;
  logic [2:0] cnt_nx;
  logic [31:0] ext_word;

  // ----------------------------------------------------------------------
  // widening of fetched data
  // ----------------------------------------------------------------------
  // memory hands back the bytes starting at the requested address in the low lanes
  always_comb
  begin
    case (q.kind)
      ltre_pkg::K_BYTE_ORD: ext_word = {24'h000000, mem_rdata[7:0]};
      ltre_pkg::K_BYTE_INT: ext_word = {{24{mem_rdata[7]}}, mem_rdata[7:0]};
      ltre_pkg::K_HALF_ORD: ext_word = {16'h0000, mem_rdata[15:0]};
      ltre_pkg::K_HALF_INT: ext_word = {{16{mem_rdata[15]}}, mem_rdata[15:0]};
      default: ext_word = mem_rdata;
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  // software writes are applied first so that hardware sets below win over a clear
  always_comb
  begin
    n = q;
    ev = {`LTRE_INT_W{1'b0}};
    cnt_nx = q.cnt + 3'h1;
    n.rf_we = 1'b0;
    n.mem_req = 1'b0;
    n.fault_valid = 1'b0;
    n.fault_code = `LTRE_FLT_NONE;
    n.trace_fault = 1'b0;
    n.done = 1'b0;
    n.rdata = 32'h00000000;

    // register writes
    if (reg_wr)
    begin
      case (reg_addr)
        `LTRE_OFF_PROC_CTRL:
        begin
          n.trace_en = reg_wdata[`LTRE_BIT_TRACE_EN];
          n.fault_pend = reg_wdata[`LTRE_BIT_FAULT_PEND];
        end
        `LTRE_OFF_TRACE_CTRL: n.bp_evt = reg_wdata[`LTRE_BIT_BP_EVENT];
        `LTRE_OFF_INT_MASK: n.int_mask = reg_wdata[`LTRE_INT_W-1:0];
        default: n.int_mask = q.int_mask;
      endcase
    end

    // register reads: data stand in the following cycle only
    if (reg_rd)
    begin
      case (reg_addr)
        `LTRE_OFF_PROC_CTRL:
        begin
          n.rdata[`LTRE_BIT_TRACE_EN] = q.trace_en;
          n.rdata[`LTRE_BIT_FAULT_PEND] = q.fault_pend;
        end
        `LTRE_OFF_TRACE_CTRL: n.rdata[`LTRE_BIT_BP_EVENT] = q.bp_evt;
        `LTRE_OFF_INT_STATUS:
        begin
          n.rdata[`LTRE_INT_W-1:0] = q.int_stat;
          n.int_stat = {`LTRE_INT_W{1'b0}};
        end
        `LTRE_OFF_INT_MASK: n.rdata[`LTRE_INT_W-1:0] = q.int_mask;
        `LTRE_OFF_UNIT_STATE: n.rdata = {24'h000000, q.busy, q.kind, 2'b00, q.st};
        default: n.rdata = 32'h00000000;
      endcase
    end

    // instruction sequencing
    case (q.st)
      ltre_pkg::ST_IDLE:
      begin
        if (instr_valid)
        begin
          n.dst = instr_dst;
          n.addr = instr_src;
          n.cnt = 3'h0;
          n.total = 3'h1;
          if (instr_op == `LTRE_OP_FMARK)
          begin
            if (q.trace_en)
            begin
              n.fault_pend = 1'b1;
              n.bp_evt = 1'b1;
              ev[`LTRE_INT_BP] = 1'b1;
              n.trace_fault = 1'b1;
              n.st = ltre_pkg::ST_TRACE;
            end
            n.done = 1'b1;
          end
          else if (instr_op == `LTRE_OP_INSPACC)
          begin
            n.kind = ltre_pkg::K_INSP;
            if (!seg_desc_ok)
            begin
              n.fault_valid = 1'b1;
              n.fault_code = `LTRE_FLT_BAD_DESC;
              ev[`LTRE_INT_BAD_DESC] = 1'b1;
              n.done = 1'b1;
            end
            else if (instr_src > seg_length)
            begin
              n.fault_valid = 1'b1;
              n.fault_code = `LTRE_FLT_SEG_LEN;
              ev[`LTRE_INT_SEG_LEN] = 1'b1;
              n.done = 1'b1;
            end
            else
            begin
              // the subsystem walks the tables and returns the entry of the byte's page
              n.mem_req = 1'b1;
              n.mem_pte = 1'b1;
              n.mem_addr = instr_src;
              n.st = ltre_pkg::ST_WAIT;
            end
          end
          else if (instr_op[3:0] == 4'h0)
          begin
            n.st = ltre_pkg::ST_WAIT;
            n.mem_req = 1'b1;
            n.mem_pte = 1'b0;
            n.mem_addr = instr_src;
            case (instr_op[11:4])
              `LTRE_OP_LDOB: n.kind = ltre_pkg::K_BYTE_ORD;
              `LTRE_OP_LDIB: n.kind = ltre_pkg::K_BYTE_INT;
              `LTRE_OP_LDOS: n.kind = ltre_pkg::K_HALF_ORD;
              `LTRE_OP_LDIS: n.kind = ltre_pkg::K_HALF_INT;
              `LTRE_OP_LOAD_WORD_INSTR: n.kind = ltre_pkg::K_WORDS;
              `LTRE_OP_LDL:
              begin
                n.kind = ltre_pkg::K_WORDS;
                n.total = 3'h2;
              end
              `LTRE_OP_LDT:
              begin
                n.kind = ltre_pkg::K_WORDS;
                n.total = 3'h3;
              end
              `LTRE_OP_LDQ:
              begin
                n.kind = ltre_pkg::K_WORDS;
                n.total = 3'h4;
              end
              default:
              begin
                // not one of ours: retire without effect
                n.st = ltre_pkg::ST_IDLE;
                n.mem_req = 1'b0;
                n.done = 1'b1;
              end
            endcase
          end
          else
          begin
            n.done = 1'b1;
          end
        end
      end

      ltre_pkg::ST_WAIT:
      begin
        if (mem_ack)
        begin
          n.rf_we = 1'b1;
          if (q.kind == ltre_pkg::K_INSP)
          begin
            n.rf_waddr = q.dst;
            n.rf_wdata = {30'h00000000, mem_rdata[`LTRE_RIGHTS_MSB:`LTRE_RIGHTS_LSB]};
            ev[`LTRE_INT_INSP_DONE] = 1'b1;
            n.done = 1'b1;
            n.st = ltre_pkg::ST_IDLE;
          end
          else
          begin
            // index wraps in five bits; overrunning the register banks is left undefined
            n.rf_waddr = q.dst + {2'b00, q.cnt};
            n.rf_wdata = ext_word;
            n.cnt = cnt_nx;
            if (cnt_nx == q.total)
            begin
              ev[`LTRE_INT_LOAD_DONE] = 1'b1;
              n.done = 1'b1;
              n.st = ltre_pkg::ST_IDLE;
            end
            else
            begin
              n.mem_req = 1'b1;
              n.mem_addr = q.addr + {27'h0000000, cnt_nx, 2'b00};
            end
          end
        end
      end

      ltre_pkg::ST_TRACE:
      begin
        // one blocked cycle keeps the fault ahead of any further issue
        n.st = ltre_pkg::ST_IDLE;
      end

      default: n.st = ltre_pkg::ST_IDLE;
    endcase

    n.int_stat = n.int_stat | ev;
    n.irq = |(n.int_stat & n.int_mask);
    n.busy = (n.st != ltre_pkg::ST_IDLE);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= n;
    end
  end

  // outputs come straight from the state register
  assign reg_rdata = q.rdata;
  assign irq = q.irq;
  assign instr_busy = q.busy;
  assign instr_done = q.done;
  assign mem_req = q.mem_req;
  assign mem_pte = q.mem_pte;
  assign mem_addr = q.mem_addr;
  assign rf_we = q.rf_we;
  assign rf_waddr = q.rf_waddr;
  assign rf_wdata = q.rf_wdata;
  assign fault_valid = q.fault_valid;
  assign fault_code = q.fault_code;
  assign trace_fault = q.trace_fault;

endmodule

// file: test/ltre_mem_model.sv
// memory subsystem model answering data and page table requests
`timescale 1ns/1ps
module ltre_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request and answer
  input wire logic mem_req,
  input wire logic mem_pte,
  input wire logic [31:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // extra wait cycles
  input wire logic [1:0] lat
);
  logic pend, pte;
  logic [1:0] cnt;
  logic [31:0] a, cyc;
  // byte k of memory is (k ^ 5A) so every lane differs
  function automatic logic [31:0] word_at(input logic [31:0] x);
    return {x[7:0] + 8'h03, x[7:0] + 8'h02, x[7:0] + 8'h01, x[7:0]} ^ 32'h5A5A5A5A;
  endfunction
  // one answer per request, after lat more cycles
  always_ff @(posedge clk)
  begin
    mem_ack <= 1'b0;
    cyc <= cyc + 32'h1;
    if (rst)
    begin
      pend <= 1'b0;
      cyc <= 32'h00000000;
    end
    else if (mem_req)
    begin
      pend <= 1'b1;
      pte <= mem_pte;
      a <= mem_addr;
      cnt <= lat;
    end
    else if (pend && cnt == 2'h0)
    begin
      pend <= 1'b0;
      mem_ack <= 1'b1;
    end
    else if (pend)
      cnt <= cnt - 2'h1;
  end
  // entry rights follow address bits 13:12; bus churns when idle so stale data never matches
  assign mem_rdata = !mem_ack ? ~cyc : pte ? {a[31:12], 9'h000, a[13:12], 1'b1}
    : word_at(a);
endmodule

// file: test/ltre_unit_asserts.sv
// concurrent checks on the load/trace/rights unit ports
`timescale 1ns/1ps
module ltre_unit_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction issue
  input wire logic instr_valid,
  input wire logic [11:0] instr_op,
  input wire logic [31:0] instr_src,
  input wire logic instr_busy,
  input wire logic instr_done,
  input wire logic seg_desc_ok,
  input wire logic [31:0] seg_length,
  // memory, register file, faults
  input wire logic mem_req,
  input wire logic mem_pte,
  input wire logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic rf_we,
  input wire logic [31:0] rf_wdata,
  input wire logic fault_valid,
  input wire logic [2:0] fault_code,
  input wire logic trace_fault
);
  logic acc, pte_q;
  logic [7:0] op_q;
  logic [31:0] rd_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  assign acc = instr_valid && !instr_busy;
  // last accepted opcode, open lookup and the read bus word of the previous cycle
  always_ff @(posedge clk)
  begin
    rd_q <= mem_rdata;
    if (rst)
    begin
      op_q <= 8'h00;
      pte_q <= 1'b0;
    end
    else
    begin
      if (acc)
        op_q <= instr_op[11:4];
      if (mem_req)
        pte_q <= mem_pte;
      else if (mem_ack)
        pte_q <= 1'b0;
    end
  end
  a_trace_cause: assert property (
    trace_fault |-> instr_done && $past(acc && instr_op == 12'h66C))
    else $error("stray trace fault");
  a_trace_first: assert property (
    trace_fault |-> instr_busy ##1 !instr_busy)
    else $error("trace fault timing");
  a_bad_desc: assert property (
    fault_valid && fault_code == 3'h1 |-> $past(acc && instr_op == 12'h613 && !seg_desc_ok))
    else $error("descriptor fault");
  a_seg_len: assert property (
    fault_valid && fault_code == 3'h2 |-> $past(seg_desc_ok && instr_src > seg_length))
    else $error("length fault");
  a_insp_req: assert property (
    acc && instr_op == 12'h613 && seg_desc_ok && instr_src <= seg_length
    |=> mem_req && mem_pte && mem_addr == $past(instr_src))
    else $error("lookup request");
  a_load_req: assert property (
    acc && instr_op inside {12'h800, 12'h880, 12'hC00, 12'hC80, 12'h900, 12'h980, 12'hA00,
    12'hB00} |=> mem_req && !mem_pte && mem_addr == $past(instr_src))
    else $error("load request");
  a_rights_copy: assert property (
    pte_q && mem_ack |=> rf_we && rf_wdata == {30'h0, rd_q[2:1]})
    else $error("rights field");
  a_zero_ext: assert property (
    op_q == 8'h80 && mem_ack |=> rf_we && rf_wdata == {24'h0, rd_q[7:0]})
    else $error("byte widening");
  c_trace: cover property (trace_fault);
  c_len: cover property (fault_valid && fault_code == 3'h2);
  c_quad: cover property (rf_we && op_q == 8'hB0);
endmodule
bind ltre_unit ltre_unit_asserts i_chk (
  .clk(clk),
  .rst(rst),
  .instr_valid(instr_valid),
  .instr_op(instr_op),
  .instr_src(instr_src),
  .instr_busy(instr_busy),
  .instr_done(instr_done),
  .seg_desc_ok(seg_desc_ok),
  .seg_length(seg_length),
  .mem_req(mem_req),
  .mem_pte(mem_pte),
  .mem_addr(mem_addr),
  .mem_ack(mem_ack),
  .mem_rdata(mem_rdata),
  .rf_we(rf_we),
  .rf_wdata(rf_wdata),
  .fault_valid(fault_valid),
  .fault_code(fault_code),
  .trace_fault(trace_fault)
);

// file: test/testbench.sv
// self-checking bench for the load/trace/rights unit
`timescale 1ns/1ps
module testbench;
  logic clk, rst, reg_wr, reg_rd, irq, instr_valid, instr_busy, instr_done, seg_desc_ok;
  logic mem_req, mem_pte, mem_ack, rf_we, fault_valid, trace_fault, tf_seen;
  logic [1:0] lat;
  logic [2:0] fault_code, flt;
  logic [4:0] instr_dst, rf_waddr;
  logic [7:0] reg_addr;
  logic [11:0] instr_op;
  logic [31:0] reg_wdata, reg_rdata, instr_src, seg_length, mem_addr, mem_rdata, rf_wdata, w;
  logic [36:0] wq[$];
  logic [7:0] ops[8] = '{8'h80, 8'h88, 8'hC0, 8'hC8, 8'h90, 8'h98, 8'hA0, 8'hB0};
  logic [4:0] dsts[8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08, 5'h0C};
  int nw[8] = '{1, 1, 1, 1, 1, 2, 3, 4};
  int mismatches, samples_checked, cycles;
  ltre_unit i_dut (
    .clk(clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .irq(irq),
    .instr_valid(instr_valid),
    .instr_op(instr_op),
    .instr_dst(instr_dst),
    .instr_src(instr_src),
    .instr_busy(instr_busy),
    .instr_done(instr_done),
    .seg_desc_ok(seg_desc_ok),
    .seg_length(seg_length),
    .mem_req(mem_req),
    .mem_pte(mem_pte),
    .mem_addr(mem_addr),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata),
    .rf_we(rf_we),
    .rf_waddr(rf_waddr),
    .rf_wdata(rf_wdata),
    .fault_valid(fault_valid),
    .fault_code(fault_code),
    .trace_fault(trace_fault)
  );
  ltre_mem_model i_mem (
    .clk(clk),
    .rst(rst),
    .mem_req(mem_req),
    .mem_pte(mem_pte),
    .mem_addr(mem_addr),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata),
    .lat(lat)
  );
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // hang guard, far beyond the few hundred cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  // collect register writes and faults of the running instruction
  always @(posedge clk)
  begin
    if (rf_we)
      wq.push_back({rf_waddr, rf_wdata});
    if (trace_fault)
      tf_seen = 1'b1;
    if (fault_valid)
      flt = fault_code;
  end
  function automatic logic [31:0] word_at(input logic [31:0] x);
    return {x[7:0] + 8'h03, x[7:0] + 8'h02, x[7:0] + 8'h01, x[7:0]} ^ 32'h5A5A5A5A;
  endfunction
  task automatic wrap_up();
    $display("checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [36:0] seen, input logic [36:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_check(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(37'(reg_rdata), 37'(e));
  endtask
  // offer one instruction, wait for retirement, let trailing writes land
  task automatic issue(input logic [11:0] op, input logic [4:0] d, input logic [31:0] s,
    input logic ok);
    int n;
    wq.delete();
    tf_seen = 1'b0;
    flt = 3'h0;
    n = 0;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_dst <= d;
    instr_src <= s;
    seg_desc_ok <= ok;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    while (instr_done !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(37'(n < 300), 37'h1);
    repeat (2) @(posedge clk);
    #1;
  endtask
  initial
  begin
    rst = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd, instr_valid, instr_op, instr_dst, instr_src} = '0;
    {seg_desc_ok, lat} = '0;
    seg_length = 32'h2000;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    reg_write(8'h14, 32'hFFFFFFFF);
    reg_write(8'h10, 32'hFFFFFFFF);
    for (int a = 0; a <= 20; a += 4)
      reg_check(8'(a), 32'h0);
    $display("test registers done");
    issue(12'h66C, 5'd0, 32'h0, 1'b1);
    check(37'(tf_seen), 37'h0);
    reg_check(8'h08, 32'h0);
    reg_write(8'h00, 32'h1);
    reg_write(8'h0C, 32'h1F);
    issue(12'h66C, 5'd0, 32'h0, 1'b1);
    check(37'(tf_seen), 37'h1);
    check(37'(irq), 37'h1);
    reg_check(8'h00, 32'h401);
    reg_check(8'h04, 32'h00800000);
    reg_check(8'h08, 32'h1);
    reg_check(8'h08, 32'h0);
    check(37'(irq), 37'h0);
    // opcodes outside the family must retire with no write; 66D is also checked for no trace or fault
    issue(12'h66D, 5'h01, 32'h0, 1'b1);
    check({33'(wq.size()), tf_seen, flt}, 37'h0);
    issue(12'h8C0, 5'h01, 32'h10A0, 1'b1);
    check(37'(wq.size()), 37'h0);
    $display("test trace done");
    issue(12'h613, 5'd9, 32'h2000, 1'b1);
    check({32'(wq.size()), 5'd0}, 37'h20);
    check(wq[0], {5'd9, 32'h2});
    issue(12'h613, 5'd9, 32'h2001, 1'b1);
    check({34'(wq.size()), flt}, 37'h2);
    issue(12'h613, 5'd9, 32'h1000, 1'b0);
    check({34'(wq.size()), flt}, 37'h1);
    reg_check(8'h08, 32'h16);
    $display("test rights done");
    reg_write(8'h0C, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      lat <= 2'(i);
      issue({ops[i], 4'h0}, dsts[i], 32'h10A0, 1'b1);
      w = word_at(32'h10A0);
      case (ops[i])
        8'h80: w = {24'h0, w[7:0]};
        8'h88: w = {16'h0, w[15:0]};
        8'hC0: w = {{24{w[7]}}, w[7:0]};
        8'hC8: w = {{16{w[15]}}, w[15:0]};
        default: ;
      endcase
      check(37'(wq.size()), 37'(nw[i]));
      for (int k = 0; k < nw[i]; k++)
        check(wq[k], {dsts[i] + 5'(k), k == 0 ? w : word_at(32'h10A0 + 32'(4 * k))});
    end
    check(37'(irq), 37'h0);
    reg_check(8'h08, 32'h8);
    $display("test loads done");
    wrap_up();
  end
endmodule
